/* common/dpt_pkg.sv */
// Package: register map, field layout and types of the dual prescaled timer
package dpt_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [15:0] ADDR_CONTROL    = 16'hfe18;
	localparam logic [15:0] ADDR_PRESCALE   = 16'hfe19;
	localparam logic [15:0] ADDR_LOW_COUNT  = 16'hfe1a;
	localparam logic [15:0] ADDR_HIGH_COUNT = 16'hfe1b;
	localparam logic [15:0] ADDR_LOW_MATCH  = 16'hfe1c;
	localparam logic [15:0] ADDR_HIGH_MATCH = 16'hfe1d;
	localparam logic [15:0] ADDR_EVENT_CFG  = 16'hfe1e;

	// ------------------------------------------------------------
	// Reset values and constants
	// ------------------------------------------------------------
	localparam logic [7:0] RST_CONTROL   = 8'h00;
	localparam logic [7:0] RST_PRESCALE  = 8'h00;
	localparam logic [7:0] RST_MATCH     = 8'h00;
	localparam logic [7:0] RST_EVENT_CFG = 8'h00;
	localparam logic [7:0] COUNT_ZERO    = 8'h00;
	localparam logic [7:0] COUNT_TOP     = 8'hff;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	localparam int         EVENT_SEL_BIT = 0;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic high_run;
		logic low_run;
		logic cascade_select;
		logic pwm_select;
		logic high_match_flag;
		logic high_irq_enable;
		logic low_match_flag;
		logic low_irq_enable;
	} dpt_ctrl_s;

	typedef struct packed {
		logic       high_prescale_enable;
		logic [2:0] high_prescale_code;
		logic       low_prescale_enable;
		logic [2:0] low_prescale_code;
	} dpt_presc_s;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} dpt_bus_s;

endpackage

/* hdl/dpt_timer.sv */
// Dual 8-bit prescaled timer with toggle and PWM outputs
//
// Behaviour
// - Mode 0: two independent timers, low may count events
// - Mode 0: pins toggle once per counter period
// - Mode 1: two 8-bit PWMs on cycle clock
// - Mode 2: high counts low matches, 16-bit
// - Mode 3: low PWM, high counts PWM periods
// - Period interrupt requests only when enabled
// - Stopped counter holds its pin high
// - Running with match FFH holds pin low
// - Low prescaler runs with low run bit
// - Low prescaler input: half rate modes 0/2
// - Low prescale divide 1, or 2 to 256
// - Low prescaler cleared on stop or reset
// - High prescaler runs with high run bit
// - High prescaler input depends on mode
// - High prescale uses same divide encoding
// - High prescaler cleared on stop or reset
// - Low counter advances on prescaler tick
// - Low match when count equals buffer
// - Low counter cleared on stop, match 0/2
// - Buffer tracks when stopped, reloads at zero
// - PWM pin low on overflow, high on match
// - High counter cleared on stop, match 0/2/3
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module dpt_timer (
	input  wire logic        CLK_SYS_I,
	input  wire logic        NRST_I,
	input  wire logic [15:0] ADDR_I,
	input  wire logic [7:0]  WDATA_I,
	input  wire logic        WR_I,
	input  wire logic        RD_I,
	input  wire logic        EVENT_I,
	output var  logic [7:0]  RDATA_O,
	output var  logic        LOW_PIN_O,
	output var  logic        HIGH_PIN_O,
	output var  logic        LOW_IRQ_O,
	output var  logic        HIGH_IRQ_O
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	dpt_pkg::dpt_bus_s   bus;
	dpt_pkg::dpt_ctrl_s  ctrl;
	dpt_pkg::dpt_presc_s presc;
	logic [7:0] low_match_reg;
	logic [7:0] high_match_reg;
	logic [7:0] event_cfg;
	logic [7:0] low_cnt;
	logic [7:0] high_cnt;
	logic [7:0] low_buf;
	logic [7:0] high_buf;
	logic [7:0] low_pre;
	logic [7:0] high_pre;
	logic       div2;
	logic       ev_meta;
	logic       ev_sync;
	logic       ev_prev;
	logic       ev_edge;
	logic       low_in;
	logic       high_in;
	logic       low_tick;
	logic       high_tick;
	logic       low_match;
	logic       high_match;
	logic       low_period;
	logic       high_period;
	logic       low_pwm_mode;
	logic       high_pwm_mode;
	logic       low_clr_on_match;
	logic       high_clr_on_match;
	logic [7:0] low_limit;
	logic [7:0] high_limit;
	logic [7:0] next_rdata;

	assign bus = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

	// Divide enable and code to a terminal count of the prescaler
	function automatic logic [7:0] pre_limit(input logic en,
	                                         input logic [2:0] code);
		logic [8:0] span;
		span = 9'h002 << code;
		pre_limit = en ? 8'(span - 9'h001) : 8'h00;
	endfunction

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	assign low_pwm_mode      = ctrl.pwm_select;
	assign high_pwm_mode     = ctrl.pwm_select && !ctrl.cascade_select;
	assign low_clr_on_match  = !ctrl.pwm_select;
	assign high_clr_on_match = !high_pwm_mode;
	assign low_limit  = pre_limit(presc.low_prescale_enable,
	                              presc.low_prescale_code);
	assign high_limit = pre_limit(presc.high_prescale_enable,
	                              presc.high_prescale_code);

	// ------------------------------------------------------------
	// Event input and half-rate base tick
	// ------------------------------------------------------------
	// synchronise event pin
	always_ff @(posedge CLK_SYS_I) begin
		if (!NRST_I) begin
			ev_meta <= 1'b0;
			ev_sync <= 1'b0;
			ev_prev <= 1'b0;
		end else begin
			ev_meta <= EVENT_I;
			ev_sync <= ev_meta;
			ev_prev <= ev_sync;
		end
	end
	assign ev_edge = ev_sync && !ev_prev;

	always_ff @(posedge CLK_SYS_I) begin
		if (!NRST_I) begin
			div2 <= 1'b0;
		end else begin
			div2 <= !div2;
		end
	end

	// ------------------------------------------------------------
	// Prescaler inputs
	// ------------------------------------------------------------
	// low input source
	always_comb begin
		if (low_pwm_mode) begin
			low_in = 1'b1;
		end else if (event_cfg[dpt_pkg::EVENT_SEL_BIT]) begin
			low_in = ev_edge;
		end else begin
			low_in = div2;
		end
	end

	always_comb begin
		unique case ({ctrl.cascade_select, ctrl.pwm_select})
			2'b00: high_in = div2;
			2'b01: high_in = 1'b1;
			2'b10: high_in = low_tick && low_match;
			2'b11: high_in = low_tick && (low_cnt == dpt_pkg::COUNT_TOP);
		endcase
	end

	// At or above: a smaller divide written while running must not wrap
	assign low_tick  = ctrl.low_run && low_in && (low_pre >= low_limit);
	assign high_tick = ctrl.high_run && high_in
	                   && (high_pre >= high_limit);

	// ------------------------------------------------------------
	// Prescalers
	// ------------------------------------------------------------
	// low prescaler
	always_ff @(posedge CLK_SYS_I) begin
		if (!NRST_I || !ctrl.low_run) begin
			low_pre <= dpt_pkg::COUNT_ZERO;
		end else if (low_in) begin
			low_pre <= low_tick ? dpt_pkg::COUNT_ZERO : low_pre + 8'h01;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (!NRST_I || !ctrl.high_run) begin
			high_pre <= dpt_pkg::COUNT_ZERO;
		end else if (high_in) begin
			high_pre <= high_tick ? dpt_pkg::COUNT_ZERO : high_pre + 8'h01;
		end
	end

	// ------------------------------------------------------------
	// Counters and match buffers
	// ------------------------------------------------------------
	// match against buffer
	assign low_match  = (low_cnt == low_buf);
	assign high_match = (high_cnt == high_buf);
	assign low_period  = low_tick && (low_clr_on_match ? low_match
	                     : low_cnt == dpt_pkg::COUNT_TOP);
	assign high_period = high_tick && (high_clr_on_match ? high_match
	                     : high_cnt == dpt_pkg::COUNT_TOP);

	always_ff @(posedge CLK_SYS_I) begin
		if (!NRST_I || !ctrl.low_run) begin
			low_cnt <= dpt_pkg::COUNT_ZERO;
		end else if (low_tick) begin
			low_cnt <= (low_clr_on_match && low_match)
			           ? dpt_pkg::COUNT_ZERO : low_cnt + 8'h01;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (!NRST_I || !ctrl.high_run) begin
			high_cnt <= dpt_pkg::COUNT_ZERO;
		end else if (high_tick) begin
			high_cnt <= (high_clr_on_match && high_match)
			            ? dpt_pkg::COUNT_ZERO : high_cnt + 8'h01;
		end
	end

	// buffers reload only at zero or while stopped, so a period is never cut short
	always_ff @(posedge CLK_SYS_I) begin
		if (!NRST_I) begin
			low_buf  <= dpt_pkg::RST_MATCH;
			high_buf <= dpt_pkg::RST_MATCH;
		end else begin
			if (!ctrl.low_run || low_cnt == dpt_pkg::COUNT_ZERO) begin
				low_buf <= low_match_reg;
			end
			if (!ctrl.high_run || high_cnt == dpt_pkg::COUNT_ZERO) begin
				high_buf <= high_match_reg;
			end
		end
	end

	// ------------------------------------------------------------
	// Output pins
	// ------------------------------------------------------------
	// low pin
	always_ff @(posedge CLK_SYS_I) begin
		if (!NRST_I || !ctrl.low_run) begin
			LOW_PIN_O <= 1'b1;
		end else if (low_match_reg == dpt_pkg::COUNT_TOP) begin
			LOW_PIN_O <= 1'b0;
		end else if (low_pwm_mode) begin
			if (low_tick && low_match) begin
				LOW_PIN_O <= 1'b1;
			end else if (low_tick && low_cnt == dpt_pkg::COUNT_TOP) begin
				LOW_PIN_O <= 1'b0;
			end
		end else if (low_tick && low_match) begin
			LOW_PIN_O <= !LOW_PIN_O;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (!NRST_I || !ctrl.high_run) begin
			HIGH_PIN_O <= 1'b1;
		end else if (high_match_reg == dpt_pkg::COUNT_TOP) begin
			HIGH_PIN_O <= 1'b0;
		end else if (high_pwm_mode) begin
			if (high_tick && high_match) begin
				HIGH_PIN_O <= 1'b1;
			end else if (high_tick && high_cnt == dpt_pkg::COUNT_TOP) begin
				HIGH_PIN_O <= 1'b0;
			end
		end else if (high_tick && high_match) begin
			HIGH_PIN_O <= !HIGH_PIN_O;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// flags: a period in the clearing cycle still sets the flag
	always_ff @(posedge CLK_SYS_I) begin
		if (!NRST_I) begin
			ctrl <= dpt_pkg::RST_CONTROL;
		end else begin
			if (bus.wr && bus.addr == dpt_pkg::ADDR_CONTROL) begin
				ctrl <= bus.wdata;
			end
			if (low_period) begin
				ctrl.low_match_flag <= 1'b1;
			end
			if (high_period) begin
				ctrl.high_match_flag <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (!NRST_I) begin
			presc          <= dpt_pkg::RST_PRESCALE;
			low_match_reg  <= dpt_pkg::RST_MATCH;
			high_match_reg <= dpt_pkg::RST_MATCH;
			event_cfg      <= dpt_pkg::RST_EVENT_CFG;
		end else if (bus.wr) begin
			unique case (bus.addr)
				dpt_pkg::ADDR_PRESCALE:   presc          <= bus.wdata;
				dpt_pkg::ADDR_LOW_MATCH:  low_match_reg  <= bus.wdata;
				dpt_pkg::ADDR_HIGH_MATCH: high_match_reg <= bus.wdata;
				dpt_pkg::ADDR_EVENT_CFG:  event_cfg      <= bus.wdata;
				default: ;
			endcase
		end
	end

	always_comb begin
		unique case (bus.addr)
			dpt_pkg::ADDR_CONTROL:    next_rdata = ctrl;
			dpt_pkg::ADDR_PRESCALE:   next_rdata = presc;
			dpt_pkg::ADDR_LOW_COUNT:  next_rdata = low_cnt;
			dpt_pkg::ADDR_HIGH_COUNT: next_rdata = high_cnt;
			dpt_pkg::ADDR_LOW_MATCH:  next_rdata = low_match_reg;
			dpt_pkg::ADDR_HIGH_MATCH: next_rdata = high_match_reg;
			dpt_pkg::ADDR_EVENT_CFG:  next_rdata = event_cfg;
			default:                  next_rdata = dpt_pkg::READ_UNMAPPED;
		endcase
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge CLK_SYS_I) begin
		if (!NRST_I || !bus.rd) begin
			RDATA_O <= dpt_pkg::READ_UNMAPPED;
		end else begin
			RDATA_O <= next_rdata;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (!NRST_I) begin
			LOW_IRQ_O  <= 1'b0;
			HIGH_IRQ_O <= 1'b0;
		end else begin
			LOW_IRQ_O  <= ctrl.low_match_flag && ctrl.low_irq_enable;
			HIGH_IRQ_O <= ctrl.high_match_flag && ctrl.high_irq_enable;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_low_stop_high;
		@(posedge CLK_SYS_I) disable iff (!NRST_I)
		!ctrl.low_run ##1 !ctrl.low_run |-> LOW_PIN_O && low_cnt == 8'h00;
	endproperty
	a_low_stop_high: assert property (p_low_stop_high)
		else $error("Stopped low counter not idle");

	property p_low_ff_low;
		@(posedge CLK_SYS_I) disable iff (!NRST_I)
		ctrl.low_run && low_match_reg == 8'hff |=> !LOW_PIN_O;
	endproperty
	a_low_ff_low: assert property (p_low_ff_low)
		else $error("Low pin not held low at match FFH");

	property p_low_match_clear;
		@(posedge CLK_SYS_I) disable iff (!NRST_I)
		ctrl.low_run && !ctrl.pwm_select && low_tick && low_match
		##1 ctrl.low_run |-> low_cnt == 8'h00;
	endproperty
	a_low_match_clear: assert property (p_low_match_clear)
		else $error("Low counter not cleared on match");

	property p_flag_set;
		@(posedge CLK_SYS_I) disable iff (!NRST_I)
		low_period |=> ctrl.low_match_flag;
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("Low flag lost at period");

	property p_irq_gate;
		@(posedge CLK_SYS_I) disable iff (!NRST_I)
		ctrl.high_match_flag && ctrl.high_irq_enable |=> HIGH_IRQ_O
		##1 (!ctrl.high_irq_enable)[*2] |-> !HIGH_IRQ_O;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("High interrupt not gated by enable");

	property p_pre_clear;
		@(posedge CLK_SYS_I) disable iff (!NRST_I)
		!ctrl.high_run |=> high_pre == 8'h00 && high_cnt == 8'h00;
	endproperty
	a_pre_clear: assert property (p_pre_clear)
		else $error("High prescaler not cleared when stopped");

	property p_div_one;
		@(posedge CLK_SYS_I) disable iff (!NRST_I)
		ctrl.low_run && ctrl.pwm_select && !presc.low_prescale_enable
		|-> low_tick;
	endproperty
	a_div_one: assert property (p_div_one)
		else $error("Low tick missing at full rate");

	property p_buf_track;
		@(posedge CLK_SYS_I) disable iff (!NRST_I)
		!ctrl.low_run |=> low_buf == $past(low_match_reg);
	endproperty
	a_buf_track: assert property (p_buf_track)
		else $error("Low buffer does not track when stopped");

	property p_cascade_in;
		@(posedge CLK_SYS_I) disable iff (!NRST_I)
		ctrl.cascade_select && !ctrl.pwm_select && ctrl.high_run
		&& !(low_tick && low_match)
		|=> $stable(high_pre) && $stable(high_cnt);
	endproperty
	a_cascade_in: assert property (p_cascade_in)
		else $error("High section moved without a low match");

	property p_toggle;
		@(posedge CLK_SYS_I) disable iff (!NRST_I)
		ctrl.low_run && !ctrl.pwm_select && low_tick && low_match
		&& low_match_reg != 8'hff ##1 ctrl.low_run
		&& low_match_reg != 8'hff |-> LOW_PIN_O != $past(LOW_PIN_O);
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("Low pin did not toggle on match");

	property p_pwm_low;
		@(posedge CLK_SYS_I) disable iff (!NRST_I)
		ctrl.low_run && ctrl.pwm_select && low_tick
		&& low_cnt == 8'hff && low_buf != 8'hff
		&& low_match_reg != 8'hff |=> !LOW_PIN_O;
	endproperty
	a_pwm_low: assert property (p_pwm_low)
		else $error("PWM pin not cleared on overflow");

endmodule

`default_nettype wire

/* sim/dpt_event_model.sv */
// Partner model: pulse source on the external event pin
`timescale 1ns/10ps
`default_nettype none

module dpt_event_model (
	input  wire logic       clk_sys_i,
	input  wire logic       nrst_i,
	input  wire logic       go_i,
	input  wire logic [3:0] count_i,
	output var  logic       event_o,
	output var  logic       busy_o
);
	logic [3:0] left;
	logic [2:0] phase;

	// ----------------------------------------
	// Pulse train
	// ----------------------------------------
	// Four high, four low: slow enough for a two-flop sync to see every edge
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			left <= 4'h0;
			phase <= 3'h0;
			event_o <= 1'b0;
		end else if (go_i) begin
			left <= count_i;
			phase <= 3'h0;
		end else if (left != 4'h0) begin
			event_o <= ~phase[2];
			phase <= phase + 3'h1;
			if (phase == 3'h7) begin
				left <= left - 4'h1;
			end
		end
	end

	assign busy_o = (left != 4'h0);
endmodule

`default_nettype wire

/* sim/dpt_timer_tb_top.sv */
// Testbench: register access and pin timing of the dual timer
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) begin \
	total_checks++; \
	if ((got) !== (exp)) begin \
		miscompares++; \
		$display("MISMATCH %s exp %0h got %0h", what, exp, got); \
	end \
end

module dpt_timer_tb_top;
	localparam logic [15:0] A_CTL = dpt_pkg::ADDR_CONTROL;
	localparam logic [15:0] A_PRE = dpt_pkg::ADDR_PRESCALE;
	localparam logic [15:0] A_LC  = dpt_pkg::ADDR_LOW_COUNT;
	localparam logic [15:0] A_LM  = dpt_pkg::ADDR_LOW_MATCH;
	localparam logic [15:0] A_HM  = dpt_pkg::ADDR_HIGH_MATCH;
	localparam logic [15:0] A_EV  = dpt_pkg::ADDR_EVENT_CFG;

	logic             clk_sys;
	logic             nrst;
	dpt_pkg::dpt_bus_s bus;
	logic [7:0]       rdata;
	logic             low_pin;
	logic             high_pin;
	logic             low_irq;
	logic             high_irq;
	logic             event_pin;
	logic             ev_go;
	logic             ev_busy;
	logic [3:0]       ev_count;
	logic [7:0]       d;
	int               miscompares = 0;
	int               total_checks = 0;
	int               cycles = 0;

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	dpt_timer i_dut (
		.CLK_SYS_I (clk_sys),
		.NRST_I    (nrst),
		.ADDR_I    (bus.addr),
		.WDATA_I   (bus.wdata),
		.WR_I      (bus.wr),
		.RD_I      (bus.rd),
		.EVENT_I   (event_pin),
		.RDATA_O   (rdata),
		.LOW_PIN_O (low_pin),
		.HIGH_PIN_O(high_pin),
		.LOW_IRQ_O (low_irq),
		.HIGH_IRQ_O(high_irq)
	);

	dpt_event_model i_events (
		.clk_sys_i(clk_sys),
		.nrst_i   (nrst),
		.go_i     (ev_go),
		.count_i  (ev_count),
		.event_o  (event_pin),
		.busy_o   (ev_busy)
	);

	// ----------------------------------------
	// Bus and pin helpers
	// ----------------------------------------
	task automatic test_done();
		if (miscompares == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
	endtask

	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		bus.addr <= a;
		bus.wdata <= v;
		bus.wr <= 1'b1;
		@(posedge clk_sys);
		bus.wr <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic chk_rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		#1;
		d = rdata;
		`CHK($sformatf("reg %h", a), e, d)
		@(posedge clk_sys);
	endtask

	function automatic logic pin(input logic hi);
		return hi ? high_pin : low_pin;
	endfunction

	// Skips any partial level so only whole levels are measured
	task automatic chk_span(input logic hi, input logic lvl, input int e);
		int g;
		int n;
		g = 0;
		n = 0;
		while (pin(hi) === lvl && g < 9000) begin
			tick();
			g++;
		end
		while (pin(hi) !== lvl && g < 9000) begin
			tick();
			g++;
		end
		while (pin(hi) === lvl && g < 9000) begin
			tick();
			g++;
			n++;
		end
		`CHK($sformatf("pin %0d level %0d cycles", hi, lvl), e, n)
	endtask

	task automatic events(input logic [3:0] k);
		ev_count <= k;
		ev_go <= 1'b1;
		@(posedge clk_sys);
		ev_go <= 1'b0;
		cyc(1);
		while (ev_busy === 1'b1) begin
			cyc(1);
		end
		// Room for the two-flop sync and the pin update
		cyc(8);
		tick();
	endtask

	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			miscompares++;
			test_done();
		end
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		logic [7:0] p;
		logic       p0;
		bus = '0;
		nrst = 1'b0;
		ev_go = 1'b0;
		ev_count = 4'h0;
		cyc(3);
		nrst <= 1'b1;
		cyc(2);
		for (int i = 0; i < 8; i++) begin
			chk_rd(16'hfe18 + 16'(i), 8'h00);
		end
		`CHK("pins idle", 2'b11, {low_pin, high_pin})
		wr(A_CTL, 8'h3c);
		tick();
		`CHK("high irq", 1'b1, high_irq)
		chk_rd(A_CTL, 8'h3c);
		wr(A_CTL, 8'h38);
		tick();
		`CHK("high irq masked", 1'b0, high_irq)
		wr(A_PRE, 8'ha5);
		chk_rd(A_PRE, 8'ha5);
		wr(A_HM, 8'hc3);
		chk_rd(A_HM, 8'hc3);
		wr(A_LC, 8'h77);
		chk_rd(A_LC, 8'h00);
		wr(A_CTL, 8'h34);
		tick();
		`CHK("high irq cleared", 1'b0, high_irq)
		for (int i = 0; i < 4; i++) begin
			p = (i == 0) ? 8'h00 : 8'h08 + 8'(i - 1);
			wr(A_CTL, 8'h00);
			wr(A_PRE, p);
			wr(A_LM, 8'h03);
			wr(A_CTL, 8'h50);
			chk_span(1'b0, 1'b0, 4 << i);
			chk_span(1'b0, 1'b1, 252 << i);
		end
		wr(A_CTL, 8'h00);
		wr(A_PRE, 8'h80);
		wr(A_HM, 8'h07);
		wr(A_CTL, 8'h90);
		chk_span(1'b1, 1'b0, 16);
		chk_span(1'b1, 1'b1, 496);
		wr(A_CTL, 8'h00);
		wr(A_PRE, 8'h98);
		wr(A_LM, 8'h04);
		wr(A_HM, 8'h02);
		wr(A_CTL, 8'hc0);
		chk_span(1'b0, 1'b1, 20);
		chk_span(1'b0, 1'b0, 20);
		chk_span(1'b1, 1'b0, 24);
		chk_span(1'b1, 1'b1, 24);
		wr(A_CTL, 8'h00);
		wr(A_LM, 8'hff);
		wr(A_CTL, 8'h40);
		cyc(2);
		tick();
		`CHK("low pin at match FF", 1'b0, low_pin)
		wr(A_CTL, 8'h00);
		tick();
		`CHK("low pin stopped", 1'b1, low_pin)
		chk_rd(A_LC, 8'h00);
		wr(A_PRE, 8'h00);
		wr(A_LM, 8'h04);
		wr(A_CTL, 8'h41);
		for (int k = 0; k < 40 && low_irq !== 1'b1; k++) begin
			tick();
		end
		`CHK("low irq", 1'b1, low_irq)
		wr(A_CTL, 8'h41);
		tick();
		`CHK("low irq cleared", 1'b0, low_irq)
		wr(A_CTL, 8'h40);
		cyc(30);
		tick();
		`CHK("low irq masked", 1'b0, low_irq)
		chk_rd(A_CTL, 8'h42);
		wr(A_CTL, 8'h00);
		wr(A_EV, 8'h01);
		wr(A_LM, 8'h02);
		wr(A_CTL, 8'h40);
		cyc(3);
		tick();
		p0 = low_pin;
		events(4'h2);
		`CHK("event pin early", p0, low_pin)
		chk_rd(A_LC, 8'h02);
		events(4'h1);
		`CHK("event pin toggled", ~p0, low_pin)
		events(4'h3);
		`CHK("event pin back", p0, low_pin)
		wr(A_CTL, 8'h00);
		wr(A_EV, 8'h00);
		wr(A_LM, 8'h01);
		wr(A_HM, 8'h01);
		wr(A_CTL, 8'he0);
		chk_span(1'b0, 1'b1, 4);
		chk_span(1'b1, 1'b1, 8);
		wr(A_CTL, 8'h00);
		wr(A_LM, 8'h00);
		wr(A_HM, 8'h00);
		wr(A_PRE, 8'h0f);
		wr(A_CTL, 8'h40);
		chk_span(1'b0, 1'b1, 512);
		wr(A_CTL, 8'h00);
		wr(A_PRE, 8'h00);
		wr(A_CTL, 8'hf0);
		chk_span(1'b1, 1'b0, 256);
		chk_span(1'b0, 1'b0, 1);
		test_done();
	end
endmodule

`default_nettype wire
